// [design/sdes_status.sv]
// Double-buffered, read-to-clear discard event status with its interrupt mask.
`include "sdes_params.svh"

module sdes_status
(
  input  wire logic                      clk,
  input  wire logic                      srst,
  input  wire sdes_pkg::sdes_evt_t       evt,
  input  wire logic                      csr_sel,
  input  wire logic                      csr_wr,
  input  wire logic [`SDES_ADDR_W-1:0]   csr_addr,
  input  wire logic [`SDES_DATA_W-1:0]   csr_wdata,
  output logic      [`SDES_DATA_W-1:0]   csr_rdata,
  output logic                           csr_rvalid,
  output logic                           pending,
  output logic                           irq
);
  import sdes_pkg::*;

  sdes_status_t            stat_r;
  sdes_status_t            stat_nxt;
  sdes_status_t            stat_base;
  logic                    mask_r;
  logic                    mask_nxt;
  logic [`SDES_DATA_W-1:0] rdata_r;
  logic [`SDES_DATA_W-1:0] rdata_nxt;
  logic                    rvalid_r;
  logic                    enc_drop;
  logic [3:0]              enc_reason;
  logic                    drop_hit;
  logic                    port_ok;
  logic                    fill_a;
  logic                    fill_b;
  logic                    rd_stat;
  logic                    rd_mask;
  logic                    wr_mask;
  logic [`SDES_DATA_W-1:0] stat_word;
  logic [`SDES_DATA_W-1:0] mask_word;

  // One shared encoder serves both sets, so their reason encodings are identical.
  sdes_reason_enc u_enc
  (
    .cond   (evt.cond),
    .drop   (enc_drop),
    .reason (enc_reason)
  );

  // A frame tagged with the reserved port code is not captured at all.
  assign port_ok  = (evt.src_port != `SDES_PORT_RSVD);
  assign drop_hit = evt.valid & enc_drop & port_ok;

  // One register number compare, shared by the read and write decodes.
  function automatic logic reg_hit(input logic [`SDES_ADDR_W-1:0] addr,
                                   input logic [`SDES_ADDR_W-1:0] num);
    return (addr == num);
  endfunction

  assign rd_stat = csr_sel & ~csr_wr & reg_hit(csr_addr, `SDES_REG_STATUS);
  assign rd_mask = csr_sel & ~csr_wr & reg_hit(csr_addr, `SDES_REG_MASK);
  assign wr_mask = csr_sel &  csr_wr & reg_hit(csr_addr, `SDES_REG_MASK);

  // Read data is the contents before the clear takes effect.
  assign stat_word = {{`SDES_RSVD_W{1'b0}}, stat_r};
  assign mask_word = {{(`SDES_DATA_W-1){1'b0}}, mask_r};
  assign rdata_nxt = rd_stat ? stat_word : (rd_mask ? mask_word : '0);

  // A status read clears first; a capture in the same cycle then lands in the fresh state.
  assign stat_base = rd_stat ? '0 : stat_r;
  assign fill_a    = drop_hit & ~stat_base.a_valid;
  assign fill_b    = drop_hit &  stat_base.a_valid & ~stat_base.b_valid;

  always_comb
  begin
    stat_nxt = stat_base;
    if (drop_hit)
      stat_nxt.pending = 1'b1;
    if (fill_a)
    begin
      stat_nxt.a_valid  = 1'b1;
      stat_nxt.a_reason = enc_reason;
      stat_nxt.a_port   = evt.src_port;
    end
    if (fill_b)
    begin
      stat_nxt.b_valid  = 1'b1;
      stat_nxt.b_reason = enc_reason;
      stat_nxt.b_port   = evt.src_port;
    end
  end

  // Writes to the status register are ignored; only the mask is writable.
  assign mask_nxt = wr_mask ? csr_wdata[0] : mask_r;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      stat_r   <= '0;
      mask_r   <= `SDES_MASK_RST;
      rdata_r  <= '0;
      rvalid_r <= 1'b0;
    end
    else
    begin
      stat_r   <= stat_nxt;
      mask_r   <= mask_nxt;
      rdata_r  <= rdata_nxt;
      rvalid_r <= csr_sel & ~csr_wr;
    end
  end

  assign csr_rdata  = rdata_r;
  assign csr_rvalid = rvalid_r;
  assign pending    = stat_r.pending;
  // Masking only gates the output; the captured status is left untouched.
  assign irq        = stat_r.pending & ~mask_r;

  // Helper terms for the reason checks; vc_open, unk_open and kn_open clear the causes that outrank a later code.
  sdes_cond_t              vc;
  logic                    src_nonmem;
  logic                    vc_open;
  logic                    unk_open;
  logic                    kn_open;

  assign vc         = evt.cond;
  assign src_nonmem = vc.ingress_member_chk & ~vc.admit_non_member & ~vc.src_member;
  assign vc_open    = evt.valid & ~vc.vid_all_ones
                      & ~(vc.accept_tagged_only & vc.untagged_or_prio);
  assign unk_open   = vc_open & ~vc.da_found & vc.src_forwarding & ~src_nonmem;
  assign kn_open    = vc_open & vc.da_found & vc.src_forwarding & vc.dst_forwarding
                      & ~src_nonmem & ~(vc.ingress_member_chk & ~vc.dst_member);

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // Interrupt and pending flag.
  chk_irq_gated: assert property (irq |-> !mask_r && stat_r.pending)
    else $error("interrupt raised while masked or idle");

  chk_irq_unmask: assert property (stat_r.pending && !mask_r |-> irq)
    else $error("pending discard not signalled while unmasked");

  chk_pend_on_drop: assert property (drop_hit |=> stat_r.pending)
    else $error("discard did not set pending");

  chk_a_pending: assert property (stat_r.a_valid |-> stat_r.pending)
    else $error("captured set without pending flag");

  // Capture order into the two sets.
  chk_first_fill: assert property (
    drop_hit && !rd_stat && !stat_r.a_valid
    |=> stat_r.a_valid && !stat_r.b_valid && stat_r.a_reason == $past(enc_reason)
        && stat_r.a_port == $past(evt.src_port))
    else $error("first discard not captured in set one");

  chk_second_fill: assert property (
    drop_hit && !rd_stat && stat_r.a_valid && !stat_r.b_valid
    |=> stat_r.b_valid && stat_r.b_reason == $past(enc_reason)
        && $stable(stat_r.a_reason))
    else $error("second discard not captured in set two");

  chk_b_after_a: assert property (stat_r.b_valid |-> stat_r.a_valid)
    else $error("set two valid without set one");

  chk_full_hold: assert property (
    drop_hit && !rd_stat && stat_r.a_valid && stat_r.b_valid |=> $stable(stat_r))
    else $error("full status changed on extra discard");

  chk_idle_hold: assert property (!drop_hit && !rd_stat |=> $stable(stat_r))
    else $error("status changed without a discard or a read");

  // Read-to-clear and read data.
  chk_read_clear: assert property (rd_stat && !drop_hit |=> stat_r == '0)
    else $error("status not cleared after read");

  chk_read_keep: assert property (
    rd_stat && drop_hit |=> stat_r.a_valid && !stat_r.b_valid && stat_r.pending
                            && stat_r.a_reason == $past(enc_reason))
    else $error("capture during read was lost");

  chk_read_data: assert property (
    rd_stat |=> csr_rvalid && csr_rdata == {{`SDES_RSVD_W{1'b0}}, $past(stat_r)})
    else $error("status read data wrong or reserved bits set");

  chk_rsvd_rdata: assert property (
    csr_rvalid |-> csr_rdata[`SDES_DATA_W-1:`SDES_STAT_W] == '0)
    else $error("reserved read data bits set");

  chk_rd_unmapped: assert property (
    csr_sel && !csr_wr && !rd_stat && !rd_mask |=> csr_rdata == '0)
    else $error("unmapped register read not zero");

  chk_rvalid_read: assert property (csr_sel && !csr_wr |=> csr_rvalid)
    else $error("read not answered");

  chk_rvalid_idle: assert property (!(csr_sel && !csr_wr) |=> !csr_rvalid)
    else $error("read valid without a read");

  chk_stat_wr_ign: assert property (
    csr_sel && csr_wr && !drop_hit |=> $stable(stat_r))
    else $error("register write altered the status");

  // Legal field codes.
  chk_port_legal: assert property (
    stat_r.a_port != `SDES_PORT_RSVD && stat_r.b_port != `SDES_PORT_RSVD)
    else $error("reserved source port code captured");

  chk_rsvd_reason: assert property (
    !(stat_r.a_reason inside {`SDES_RSN_RSVD_C, `SDES_RSN_RSVD_D, `SDES_RSN_RSVD_F})
    && !(stat_r.b_reason inside {`SDES_RSN_RSVD_C, `SDES_RSN_RSVD_D, `SDES_RSN_RSVD_F}))
    else $error("reserved reason code captured");

  // Reason priority of the shared encoder.
  chk_rsn_vid: assert property (
    evt.valid && vc.vid_all_ones |-> enc_drop && enc_reason == `SDES_RSN_VID_FFF)
    else $error("all-ones VLAN id not reported");

  chk_rsn_untag: assert property (
    evt.valid && !vc.vid_all_ones && vc.accept_tagged_only && vc.untagged_or_prio
    |-> enc_drop && enc_reason == `SDES_RSN_UNTAGGED)
    else $error("untagged frame under tagged-only not reported");

  chk_rsn_unk_mem: assert property (
    vc_open && !vc.da_found && vc.src_forwarding && src_nonmem
    |-> enc_drop && enc_reason == `SDES_RSN_UNK_SRCMEM)
    else $error("unknown destination membership discard not reported");

  chk_rsn_kn_mem: assert property (
    vc_open && vc.da_found && vc.src_forwarding && vc.dst_forwarding
    && (src_nonmem || (vc.ingress_member_chk && !vc.dst_member))
    |-> enc_drop && enc_reason == (src_nonmem ? `SDES_RSN_KN_SRCMEM : `SDES_RSN_KN_DSTMEM))
    else $error("known destination membership discard not reported");

  chk_rsn_kn_stp: assert property (
    vc_open && vc.da_found && (!vc.src_forwarding || !vc.dst_forwarding)
    |-> enc_drop && enc_reason == (vc.src_forwarding ? `SDES_RSN_KN_DSTFWD : `SDES_RSN_KN_SRCFWD))
    else $error("known destination forwarding-state discard not reported");

  chk_rsn_unk_stp: assert property (
    vc_open && !vc.da_found && !vc.src_forwarding
    |-> enc_drop && enc_reason == `SDES_RSN_UNK_SRCFWD)
    else $error("unknown destination forwarding-state discard not reported");

  chk_rsn_bcast: assert property (
    unk_open && vc.da_broadcast && vc.bcast_over_limit
    |-> enc_drop && enc_reason == `SDES_RSN_BC_THROT)
    else $error("broadcast throttling discard not reported");

  chk_rsn_ucast: assert property (
    unk_open && !vc.da_broadcast && !vc.da_multicast && vc.drop_unknown_en
    |-> enc_drop && enc_reason == `SDES_RSN_UNK_UCAST)
    else $error("unknown unicast discard not reported");

  chk_rsn_mcast: assert property (
    unk_open && vc.da_multicast && !vc.da_broadcast && vc.filter_mcast_en
    |-> enc_drop && enc_reason == `SDES_RSN_UNK_MCAST)
    else $error("unknown multicast discard not reported");

  chk_rsn_same: assert property (
    kn_open && vc.same_port
    |-> enc_drop && enc_reason == `SDES_RSN_SAME_PORT)
    else $error("same-port discard not reported");

  chk_rsn_filter: assert property (
    kn_open && !vc.same_port && vc.entry_filter
    |-> enc_drop && enc_reason == `SDES_RSN_FILTER)
    else $error("filtered entry discard not reported");

  chk_rsn_none_kn: assert property (
    kn_open && !vc.same_port && !vc.entry_filter
    |-> !enc_drop)
    else $error("known destination frame discarded without cause");

  chk_rsn_none_unk: assert property (
    unk_open && !(vc.da_broadcast && vc.bcast_over_limit)
    && !(vc.drop_unknown_en && !vc.da_broadcast && !vc.da_multicast)
    && !(vc.filter_mcast_en && vc.da_multicast && !vc.da_broadcast) |-> !enc_drop)
    else $error("unknown destination frame discarded without cause");

  // Mask register.
  chk_mask_write: assert property (
    wr_mask |=> mask_r == $past(csr_wdata[0]) && ($stable(stat_r.a_valid) || $past(drop_hit)))
    else $error("mask write misbehaved");

  chk_mask_hold: assert property (!wr_mask |=> $stable(mask_r))
    else $error("mask changed without a write");

  chk_mask_reset: assert property (@(posedge clk) disable iff (1'b0)
    $past(srst) |-> mask_r && stat_r == '0)
    else $error("mask not set after reset");

endmodule // sdes_status

// [design/sdes_params.svh]
// Register numbers, field widths, reason codes and reset values of the discard status block.
`ifndef SDES_PARAMS_SVH
`define SDES_PARAMS_SVH

`define SDES_ADDR_W         16
`define SDES_DATA_W         32
`define SDES_REG_MASK       16'h1880
`define SDES_REG_STATUS     16'h1881
`define SDES_STAT_W         15
`define SDES_RSVD_W         17
`define SDES_MASK_RST       1'h1
`define SDES_PORT_RSVD      2'h3

`define SDES_RSN_UNTAGGED   4'h0
`define SDES_RSN_UNK_SRCMEM 4'h1
`define SDES_RSN_KN_SRCFWD  4'h2
`define SDES_RSN_KN_DSTFWD  4'h3
`define SDES_RSN_KN_DSTMEM  4'h4
`define SDES_RSN_KN_SRCMEM  4'h5
`define SDES_RSN_UNK_UCAST  4'h6
`define SDES_RSN_UNK_MCAST  4'h7
`define SDES_RSN_BC_THROT   4'h8
`define SDES_RSN_UNK_SRCFWD 4'h9
`define SDES_RSN_SAME_PORT  4'ha
`define SDES_RSN_FILTER     4'hb
`define SDES_RSN_RSVD_C     4'hc
`define SDES_RSN_RSVD_D     4'hd
`define SDES_RSN_VID_FFF    4'he
`define SDES_RSN_RSVD_F     4'hf

`endif

// [design/sdes_pkg.sv]
// Types shared by the discard status block and its reason encoder.
package sdes_pkg;

  // Forwarding-engine verdict inputs for one frame, all from the core clock domain.
  typedef struct packed {
    logic accept_tagged_only;
    logic untagged_or_prio;
    logic vid_all_ones;
    logic da_found;
    logic da_broadcast;
    logic da_multicast;
    logic ingress_member_chk;
    logic admit_non_member;
    logic src_member;
    logic dst_member;
    logic src_forwarding;
    logic dst_forwarding;
    logic drop_unknown_en;
    logic filter_mcast_en;
    logic bcast_over_limit;
    logic same_port;
    logic entry_filter;
  } sdes_cond_t;

  typedef struct packed {
    logic       valid;
    logic [1:0] src_port;
    sdes_cond_t cond;
  } sdes_evt_t;

  // Status layout, bit 14 down to bit 0.
  typedef struct packed {
    logic [3:0] b_reason;
    logic [1:0] b_port;
    logic       b_valid;
    logic [3:0] a_reason;
    logic [1:0] a_port;
    logic       a_valid;
    logic       pending;
  } sdes_status_t;

endpackage

// [design/sdes_reason_enc.sv]
// Classifies one frame's verdict flags into a discard flag and a four-bit reason code.
`include "sdes_params.svh"

module sdes_reason_enc
(
  input  wire sdes_pkg::sdes_cond_t cond,
  output logic                      drop,
  output logic [3:0]                reason
);
  import sdes_pkg::*;

  logic mem_chk_src;

  // Source membership failure needs checking on and non-member acceptance off.
  assign mem_chk_src = cond.ingress_member_chk & ~cond.admit_non_member & ~cond.src_member;

  // The first matching cause wins; no branch can yield a reserved code.
  always_comb
  begin
    drop   = 1'b1;
    reason = `SDES_RSN_UNTAGGED;
    if (cond.vid_all_ones)
      reason = `SDES_RSN_VID_FFF;
    else if (cond.accept_tagged_only & cond.untagged_or_prio)
      reason = `SDES_RSN_UNTAGGED;
    else if (cond.da_found)
    begin
      if (!cond.src_forwarding)
        reason = `SDES_RSN_KN_SRCFWD;
      else if (!cond.dst_forwarding)
        reason = `SDES_RSN_KN_DSTFWD;
      else if (mem_chk_src)
        reason = `SDES_RSN_KN_SRCMEM;
      else if (cond.ingress_member_chk & ~cond.dst_member)
        reason = `SDES_RSN_KN_DSTMEM;
      else if (cond.same_port)
        reason = `SDES_RSN_SAME_PORT;
      else if (cond.entry_filter)
        reason = `SDES_RSN_FILTER;
      else
        drop = 1'b0;
    end
    else if (!cond.src_forwarding)
      reason = `SDES_RSN_UNK_SRCFWD;
    else if (mem_chk_src)
      reason = `SDES_RSN_UNK_SRCMEM;
    else if (cond.da_broadcast & cond.bcast_over_limit)
      reason = `SDES_RSN_BC_THROT;
    else if (cond.drop_unknown_en & ~cond.da_broadcast & ~cond.da_multicast)
      reason = `SDES_RSN_UNK_UCAST;
    else if (cond.filter_mcast_en & cond.da_multicast & ~cond.da_broadcast)
      reason = `SDES_RSN_UNK_MCAST;
    else
      drop = 1'b0;
  end

endmodule // sdes_reason_enc

// [tb/switch_drop_event_status_tb.sv]
// Self-checking testbench of the discard event status block.
`include "sdes_params.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
  $display("Error at %0t: got %h expected %h", $time, a, b); end end

module switch_drop_event_status_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sdes_pkg::*;

  typedef struct packed {
    sdes_cond_t  cond;
    logic [1:0]  port;
    logic [31:0] exp;
  } sdes_row_t;

  logic                      clk;
  logic                      srst;
  sdes_evt_t                 evt;
  logic                      csr_sel;
  logic                      csr_wr;
  logic [`SDES_ADDR_W-1:0]   csr_addr;
  logic [`SDES_DATA_W-1:0]   csr_wdata;
  logic [`SDES_DATA_W-1:0]   csr_rdata;
  logic                      csr_rvalid;
  logic                      pending;
  logic                      irq;
  int                        num_errors;
  int                        compares;
  sdes_row_t                 rows [15];

  sdes_status u_dut (
    .clk        (clk),
    .srst       (srst),
    .evt        (evt),
    .csr_sel    (csr_sel),
    .csr_wr     (csr_wr),
    .csr_addr   (csr_addr),
    .csr_wdata  (csr_wdata),
    .csr_rdata  (csr_rdata),
    .csr_rvalid (csr_rvalid),
    .pending    (pending),
    .irq        (irq)
  );

  always #4 clk = ~clk;

  // Verdict flags that give row k; rows 0 to 11 give reason k, 12 the all-ones VLAN id.
  function automatic sdes_cond_t cnd(input int k);
    sdes_cond_t c;
    c = '0;
    c.src_member = 1'b1;
    c.dst_member = 1'b1;
    c.src_forwarding = 1'b1;
    c.dst_forwarding = 1'b1;
    c.da_found = (k inside {2, 3, 4, 5, 10, 11});
    c.ingress_member_chk = (k inside {1, 4, 5});
    case (k)
      0: begin c.accept_tagged_only = 1'b1; c.untagged_or_prio = 1'b1; end
      1, 5: c.src_member = 1'b0;
      2, 9: c.src_forwarding = 1'b0;
      3: c.dst_forwarding = 1'b0;
      4: c.dst_member = 1'b0;
      6: c.drop_unknown_en = 1'b1;
      7: begin c.filter_mcast_en = 1'b1; c.da_multicast = 1'b1; end
      8: begin c.da_broadcast = 1'b1; c.bcast_over_limit = 1'b1; end
      10: c.same_port = 1'b1;
      11: c.entry_filter = 1'b1;
      12, 14: c.vid_all_ones = 1'b1;
      default: ;
    endcase
    return c;
  endfunction

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic do_reset(input int n);
    @(posedge clk);
    srst <= 1'b1;
    repeat (n) @(posedge clk);
    srst <= 1'b0;
    #1;
  endtask

  task automatic ev(input sdes_cond_t c, input logic [1:0] p);
    @(posedge clk);
    evt <= {1'b1, p, c};
    @(posedge clk);
    evt.valid <= 1'b0;
    #1;
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    csr_sel <= 1'b1;
    csr_wr <= 1'b1;
    csr_addr <= a;
    csr_wdata <= d;
    @(posedge clk);
    csr_sel <= 1'b0;
    csr_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    int n;
    @(posedge clk);
    csr_sel <= 1'b1;
    csr_wr <= 1'b0;
    csr_addr <= a;
    @(posedge clk);
    csr_sel <= 1'b0;
    n = 0;
    #1;
    while (csr_rvalid !== 1'b1 && n < 4)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 4)
    begin
      num_errors++;
      report_and_stop();
    end
    else
      `CHK(csr_rdata, exp)
  endtask

  initial
  begin
    sdes_cond_t cx;
    clk = 1'b0;
    srst = 1'b1;
    evt = '0;
    csr_sel = 1'b0;
    csr_wr = 1'b0;
    csr_addr = '0;
    csr_wdata = '0;
    num_errors = 0;
    compares = 0;
    for (int k = 0; k < 15; k++)
    begin
      rows[k].cond = cnd(k);
      rows[k].port = (k == 14) ? 2'h3 : 2'(k % 3);
      rows[k].exp = (k > 12) ? 32'h0 :
                    {24'h0, (k == 12) ? 4'he : 4'(k), rows[k].port, 2'h3};
    end
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    #1;
    `CHK({csr_rvalid, pending, irq}, 3'h0)
    rd(`SDES_REG_MASK, 32'h1);
    @(posedge clk);
    #1;
    `CHK(csr_rvalid, 1'b0)
    for (int k = 0; k < 15; k++)
    begin
      ev(rows[k].cond, rows[k].port);
      `CHK({pending, irq}, {rows[k].exp[0], 1'b0})
      rd(`SDES_REG_STATUS, rows[k].exp);
    end
    ev(cnd(12), 2'h0);
    ev(cnd(2), 2'h1);
    ev(cnd(9), 2'h2);
    ev(cnd(11), 2'h2);
    rd(`SDES_REG_STATUS, {17'h0, 4'h2, 2'h1, 1'b1, 4'he, 2'h0, 2'h3});
    rd(`SDES_REG_STATUS, 32'h0);
    wr(`SDES_REG_MASK, 32'h0);
    rd(`SDES_REG_MASK, 32'h0);
    ev(cnd(11), 2'h1);
    `CHK({pending, irq}, 2'h3)
    wr(`SDES_REG_MASK, 32'hffff_ffff);
    `CHK({pending, irq}, 2'h2)
    wr(`SDES_REG_STATUS, 32'hffff_ffff);
    rd(16'h1882, 32'h0);
    @(posedge clk);
    evt <= {1'b1, 2'h2, cnd(12)};
    csr_sel <= 1'b1;
    csr_wr <= 1'b0;
    csr_addr <= `SDES_REG_STATUS;
    @(posedge clk);
    evt.valid <= 1'b0;
    csr_sel <= 1'b0;
    #1;
    `CHK({csr_rvalid, csr_rdata}, {1'b1, 32'hb7})
    rd(`SDES_REG_STATUS, 32'heb);
    wr(`SDES_REG_MASK, 32'h0);
    ev(cnd(3), 2'h0);
    do_reset(2);
    `CHK({pending, irq}, 2'h0)
    rd(`SDES_REG_MASK, 32'h1);
    rd(`SDES_REG_STATUS, 32'h0);
    cx = cnd(1);
    cx.admit_non_member = 1'b1;
    ev(cx, 2'h0);
    `CHK(pending, 1'b0)
    cx = cnd(5);
    cx.ingress_member_chk = 1'b0;
    ev(cx, 2'h1);
    `CHK(pending, 1'b0)
    report_and_stop();
  end
endmodule // switch_drop_event_status_tb
